// ==== src/blk_xfer_pkg.sv ====
// Purpose: Shared constants and types of the block transfer controller.
// Assumes: APB register access, 32-bit data, one aligned word per register.
package blk_xfer_pkg;

  localparam logic [11:0] CH_BASE = 12'h080;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [1:0] REG_PERIPH_ADDR = 2'h0;
  localparam logic [1:0] REG_CONTROL = 2'h1;
  localparam logic [1:0] REG_MEM_PTR = 2'h2;
  localparam logic [1:0] REG_COUNT = 2'h3;
  localparam logic [31:0] PERIPH_ADDR_RST = 32'hFFE00000;
  localparam logic [31:0] MEM_PTR_RST = 32'h00000000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [2:0] CONTROL_RST = 3'h0;
  localparam int DIR_BIT = 0;
  localparam int SIZE_LSB = 1;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10,
    SIZE_RSVD = 2'b11
  } xfer_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } xfer_state_t;

  typedef struct packed {
    logic req;
    logic write;
    xfer_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } bus_rsp_t;

endpackage

// ==== src/block_transfer_controller.sv ====
// Purpose: Multi-channel block transfer engine between memory and peripherals.
// Assumes: Triggers and bus answers come from logic on pclk; bus holds ack one cycle.
// Notes: Registers are APB mapped; channel end signals are levels, high at zero count.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module block_transfer_controller
  import blk_xfer_pkg::*;
#(
  parameter int NCH = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] trigger,
  output logic [NCH-1:0] block_end_signal,
  output bus_req_t bus_req,
  input wire bus_rsp_t bus_rsp
);

  localparam int CW = $clog2(NCH);

  logic [31:0] periph_q [NCH];
  logic [2:0] ctrl_q [NCH];
  logic [31:0] mptr_q [NCH];
  logic [15:0] cnt_q [NCH];
  logic [NCH-1:0] trig_prev_q;
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] end_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  bus_req_t req_q;
  xfer_state_t state_q;
  logic [CW-1:0] cur_q;
  logic grant_ok;
  logic [CW-1:0] grant_ch;
  logic done;
  logic wr_hit;
  logic wr_ok;
  logic [CW-1:0] wr_ch;
  logic [1:0] wr_reg;
  logic [NCH-1:0] armed;

  // Address step for one transfer; the reserved code leaves the pointer still.
  function automatic logic [31:0] size_step(input logic [1:0] sz);
    case (sz)
      SIZE_BYTE: size_step = 32'h00000001;
      SIZE_HALF: size_step = 32'h00000002;
      SIZE_WORD: size_step = 32'h00000004;
      default: size_step = 32'h00000000;
    endcase
  endfunction

  // Maps an APB address onto a channel and a register within it.
  function automatic logic decode(input logic [11:0] a, output logic [CW-1:0] ch,
                                  output logic [1:0] rg);
    logic [11:0] rel;
    rel = a - CH_BASE;
    ch = rel[CW+3:4];
    rg = rel[3:2];
    decode = (a >= CH_BASE) && (rel < CH_STRIDE * 12'(NCH));
  endfunction

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      armed[i] = (cnt_q[i] != COUNT_RST);
    end
  end

  // Lowest numbered pending channel wins the bus.
  always_comb begin
    grant_ok = 1'b0;
    grant_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_q[i] && armed[i]) begin
        grant_ok = 1'b1;
        grant_ch = CW'(i);
      end
    end
  end

  assign done = (state_q == ST_WRITE) && bus_rsp.ack;
  assign wr_hit = psel && penable && pready_q && pwrite;
  always_comb begin
    wr_ok = decode(paddr, wr_ch, wr_reg);
  end

  // APB slave: answer registered in the setup cycle, ready in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    logic [CW-1:0] rch;
    logic [1:0] rrg;
    logic hit;
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      hit = decode(paddr, rch, rrg);
      pready_q <= 1'b1;
      pslverr_q <= !hit;
      prdata_q <= 32'h00000000;
      if (hit) begin
        case (rrg)
          REG_PERIPH_ADDR: prdata_q <= periph_q[rch];
          REG_CONTROL: prdata_q <= {29'h0, ctrl_q[rch]};
          REG_MEM_PTR: prdata_q <= mptr_q[rch];
          default: prdata_q <= {16'h0, cnt_q[rch]};
        endcase
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Configuration is free per channel, so any peripheral may be served.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        periph_q[i] <= PERIPH_ADDR_RST;
        ctrl_q[i] <= CONTROL_RST;
      end
    end else if (wr_hit && wr_ok) begin
      if (wr_reg == REG_PERIPH_ADDR) begin
        periph_q[wr_ch] <= pwdata;
      end
      if (wr_reg == REG_CONTROL) begin
        ctrl_q[wr_ch] <= pwdata[2:0];
      end
    end
  end

  // Software writes win; otherwise a finished transfer advances the pointer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        mptr_q[i] <= MEM_PTR_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_hit && wr_ok && wr_ch == CW'(i) && wr_reg == REG_MEM_PTR) begin
          mptr_q[i] <= pwdata;
        end else if (done && cur_q == CW'(i)) begin
          mptr_q[i] <= mptr_q[i] + size_step(ctrl_q[i][SIZE_LSB +: 2]);
        end
      end
    end
  end

  // A count written in the cycle a transfer finishes is kept as written, not decremented.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_q[i] <= COUNT_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_hit && wr_ok && wr_ch == CW'(i) && wr_reg == REG_COUNT) begin
          cnt_q[i] <= pwdata[15:0];
        end else if (done && cur_q == CW'(i) && armed[i]) begin
          cnt_q[i] <= cnt_q[i] - 16'h0001;
        end
      end
    end
  end

  // A rising trigger marks one transfer; a new trigger beats a same-cycle clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_q <= '0;
      pend_q <= '0;
    end else begin
      trig_prev_q <= trigger;
      for (int i = 0; i < NCH; i++) begin
        if (trigger[i] && !trig_prev_q[i] && armed[i]) begin
          pend_q[i] <= 1'b1;
        end else if (!armed[i] || (state_q == ST_IDLE && grant_ok && grant_ch == CW'(i))) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // The end signal is the only completion report; the block keeps no status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        end_q[i] <= !armed[i];
      end
    end
  end

  // One read then one write per transfer; the bus is dropped between transfers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      req_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (grant_ok) begin
            cur_q <= grant_ch;
            state_q <= ST_READ;
            req_q.req <= 1'b1;
            req_q.write <= 1'b0;
            req_q.size <= xfer_size_t'(ctrl_q[grant_ch][SIZE_LSB +: 2]);
            req_q.addr <= ctrl_q[grant_ch][DIR_BIT] ? mptr_q[grant_ch]
                                                    : periph_q[grant_ch];
          end
        end
        ST_READ: begin
          if (bus_rsp.ack) begin
            state_q <= ST_WRITE;
            req_q.write <= 1'b1;
            req_q.wdata <= bus_rsp.rdata;
            req_q.addr <= ctrl_q[cur_q][DIR_BIT] ? periph_q[cur_q] : mptr_q[cur_q];
          end
        end
        ST_WRITE: begin
          if (bus_rsp.ack) begin
            state_q <= ST_IDLE;
            req_q.req <= 1'b0;
            req_q.write <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          req_q.req <= 1'b0;
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign block_end_signal = end_q;
  assign bus_req = req_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A software write to the serving channel overrides the hardware update in that cycle.
  logic sw_ptr_cur;
  logic sw_cnt_cur;
  assign sw_ptr_cur = wr_hit && wr_ok && wr_ch == cur_q && wr_reg == REG_MEM_PTR;
  assign sw_cnt_cur = wr_hit && wr_ok && wr_ch == cur_q && wr_reg == REG_COUNT;

  sequence s_grant;
    state_q == ST_IDLE && grant_ok;
  endsequence

  sequence s_finish;
    done && !sw_ptr_cur && !sw_cnt_cur;
  endsequence

  // A transfer has started when the engine leaves idle for its read phase.
  sequence s_start;
    state_q == ST_IDLE ##1 state_q == ST_READ;
  endsequence

  a_ptr_advance: assert property (s_finish |=>
      mptr_q[cur_q] ==
      $past(mptr_q[cur_q]) + size_step($past(ctrl_q[cur_q][SIZE_LSB +: 2])))
    else $error("pointer did not advance by the transfer size");
  a_cnt_decrement: assert property (s_finish and armed[cur_q] |=>
      cnt_q[cur_q] == $past(cnt_q[cur_q]) - 16'h0001)
    else $error("count did not drop by one after a transfer");
  a_no_zero_start: assert property (s_start |->
      |($past(armed) & ((NCH)'(1) << cur_q)))
    else $error("transfer started on a channel with zero count");
  a_lowest_first: assert property (s_grant |->
      ((pend_q & armed & (((NCH)'(1) << grant_ch) - (NCH)'(1))) == '0))
    else $error("a lower channel was passed over");
  // The next request may follow a release at once, but only for a granted channel.
  a_bus_release: assert property (done |=> !bus_req.req ##1
      (!bus_req.req || $past(grant_ok)))
    else $error("bus held past the end of a transfer");
  a_read_source: assert property (s_grant |=>
      bus_req.req && !bus_req.write &&
      bus_req.addr == ($past(ctrl_q[grant_ch][DIR_BIT]) ? $past(mptr_q[grant_ch])
                                                        : $past(periph_q[grant_ch])))
    else $error("read address does not follow the direction bit");
  a_write_data: assert property (state_q == ST_READ && bus_rsp.ack |=>
      bus_req.req && bus_req.write && bus_req.wdata == $past(bus_rsp.rdata))
    else $error("write data is not the data just read");
  a_count_write: assert property (wr_hit && wr_ok && wr_reg == REG_COUNT |=>
      cnt_q[$past(wr_ch)] == $past(pwdata[15:0]))
    else $error("written count was not taken");
  a_end_at_zero: assert property (s_finish and (cnt_q[cur_q] == 16'h0001) |=>
      ##1 block_end_signal[$past(cur_q, 2)])
    else $error("end signal missing after the last transfer");
  a_trigger_ignored: assert property (
      (pend_q & ~$past(pend_q) & ~$past(armed)) == '0)
    else $error("a trigger was taken on a channel with zero count");

endmodule // block_transfer_controller

// ==== verification/bus_partner.sv ====
// Purpose: Memory and peripheral bus model that answers the transfer controller.
// Assumes: A request is held until ack; ack is a one-cycle pulse.
// Notes: Read data is the inverted address; idle read data toggles every cycle.
`timescale 1ns/100ps
module bus_partner
  import blk_xfer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] dly,
  input wire bus_req_t bus_req,
  output bus_rsp_t bus_rsp
);
  logic [1:0] wait_q;

  // The answer waits dly cycles, so both prompt and slow memory are seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_rsp <= '0;
      wait_q <= 2'h0;
    end else if (bus_rsp.ack || !bus_req.req) begin
      bus_rsp.ack <= 1'b0;
      bus_rsp.rdata <= ~bus_rsp.rdata;
      wait_q <= 2'h0;
    end else if (wait_q == dly) begin
      bus_rsp.ack <= 1'b1;
      bus_rsp.rdata <= ~bus_req.addr;
    end else begin
      wait_q <= wait_q + 2'h1;
      bus_rsp.rdata <= ~bus_rsp.rdata;
    end
  end
endmodule // bus_partner

// ==== verification/tb.sv ====
// Purpose: Self-checking bench of the block transfer controller.
// Assumes: APB answers in one access cycle; memory model reads back inverted addresses.
// Notes: Expected bus writes and read data are queued and checked by a monitor.
`timescale 1ns/100ps
module tb
  import blk_xfer_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] trigger = 11'h000;
  logic [10:0] block_end_signal;
  logic [1:0] dly = 2'h0;
  bus_req_t bus_req;
  bus_rsp_t bus_rsp;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [63:0] exp_w[$];
  logic [32:0] exp_r[$];
  logic [31:0] ptr[11];
  logic [31:0] pa[11];
  logic [15:0] cnt[11];
  logic [2:0] ctl[11];

  always #5 pclk = ~pclk;

  block_transfer_controller #(.NCH(11)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger(trigger),
    .block_end_signal(block_end_signal), .bus_req(bus_req), .bus_rsp(bus_rsp));

  bus_partner mem (.pclk(pclk), .presetn(presetn), .dly(dly), .bus_req(bus_req),
    .bus_rsp(bus_rsp));

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  // Monitor: outputs are settled mid-cycle, so results are taken at the falling edge.
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk(exp_r.size() > 0 && exp_r[0] === {pslverr, prdata}, "read data");
      if (exp_r.size() > 0) void'(exp_r.pop_front());
    end
    if (bus_req.req && bus_req.write && bus_rsp.ack) begin
      chk(exp_w.size() > 0 && exp_w[0] === {bus_req.addr, bus_req.wdata}, "bus write");
      if (exp_w.size() > 0) void'(exp_w.pop_front());
    end
  end

  function automatic logic [11:0] ra(input int c, input int r);
    return CH_BASE + CH_STRIDE * 12'(c) + 12'(r * 4);
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) exp_r.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input int c, input int r, input logic [31:0] d);
    apb(1'b1, ra(c, r), d, 33'h0);
  endtask

  task automatic rd(input int c, input int r, input logic [31:0] e);
    apb(1'b0, ra(c, r), 32'h0, {1'b0, e});
  endtask

  task automatic cfg(input int c, input logic [2:0] k, input logic [15:0] n);
    pa[c] = $urandom;
    ptr[c] = $urandom;
    ctl[c] = k;
    cnt[c] = n;
    wr(c, REG_PERIPH_ADDR, pa[c]);
    wr(c, REG_CONTROL, {29'h0, k});
    wr(c, REG_MEM_PTR, ptr[c]);
    wr(c, REG_COUNT, {16'h0, n});
  endtask

  // Notes one transfer of channel c: its bus write, the new pointer and the new count.
  task automatic note(input int c);
    logic [31:0] src;
    logic [31:0] dst;
    src = ctl[c][0] ? ptr[c] : pa[c];
    dst = ctl[c][0] ? pa[c] : ptr[c];
    exp_w.push_back({dst, ~src});
    ptr[c] += 32'h1 << ctl[c][2:1];
    cnt[c]--;
  endtask

  // Pulses the triggers in m and waits up to 60 cycles for every expected bus write to be seen.
  task automatic go(input logic [10:0] m);
    for (int c = 0; c < 11; c++) begin
      if (m[c] && cnt[c] != 16'h0) note(c);
    end
    dly <= 2'($urandom);
    trigger <= m;
    @(posedge pclk);
    trigger <= 11'h000;
    repeat (60) if (exp_w.size() != 0) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    void'($urandom(32'hD7C866A0));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int c = 0; c < 11; c += 10) begin
      rd(c, REG_PERIPH_ADDR, PERIPH_ADDR_RST);
      rd(c, REG_CONTROL, {29'h0, CONTROL_RST});
      rd(c, REG_MEM_PTR, MEM_PTR_RST);
      rd(c, REG_COUNT, {16'h0, COUNT_RST});
    end
    chk(block_end_signal === 11'h7FF, "end level at reset");
    apb(1'b0, 12'h130, 32'h0, {1'b1, 32'h0});
    for (int c = 0; c < 6; c++) begin
      cfg(c, {2'(c / 2), 1'(c % 2)}, 16'h2);
      go(11'h1 << c);
      chk(block_end_signal[c] === 1'b0, "end too early");
      rd(c, REG_COUNT, 32'h1);
      go(11'h1 << c);
      rd(c, REG_MEM_PTR, ptr[c]);
      chk(block_end_signal[c] === 1'b1, "end missing");
      go(11'h1 << c);
    end
    cfg(7, 3'b011, 16'h5);
    go(11'h080);
    ptr[7] = $urandom;
    wr(7, REG_MEM_PTR, ptr[7]);
    cnt[7] = 16'h2;
    wr(7, REG_COUNT, 32'h2);
    repeat (3) go(11'h080);
    rd(7, REG_MEM_PTR, ptr[7]);
    cfg(8, 3'b100, 16'h1);
    cfg(9, 3'b000, 16'h1);
    go(11'h300);
    cfg(10, 3'b000, 16'h4);
    go(11'h400);
    // The two zero writes land while a transfer is in flight; it still completes.
    note(10);
    cnt[10] = 16'h0;
    trigger <= 11'h400;
    @(posedge pclk);
    trigger <= 11'h000;
    wr(10, REG_COUNT, 32'h0);
    wr(10, REG_COUNT, 32'h0);
    go(11'h400);
    rd(10, REG_MEM_PTR, ptr[10]);
    rd(10, REG_COUNT, 32'h0);
    repeat (5) @(posedge pclk);
    chk(exp_w.size() == 0 && exp_r.size() == 0, "results missing");
    final_report();
  end
endmodule // tb
